// ---- flow_pkg.sv ----
// Shared constants and types for the program-flow execution block
package flow_pkg;

    // ==========================================================
    // Widths
    localparam int PC_W    = 13;                  // Program space address width
    localparam int SP_W    = 8;                   // Stack pointer width
    localparam int DATA_W  = 8;                   // Working register width
    localparam int STACK_W = 16;                  // One stack entry, two bytes
    localparam int FLAG_W  = 4;

    // ==========================================================
    // Flag positions in the flag word
    localparam int FLAG_ZERO = 0;
    localparam int FLAG_CARRY = 1;
    localparam int FLAG_HALF = 2;                 // half_borrow_flag
    localparam int FLAG_WRAP = 3;                 // signed_wrap_flag

    // ==========================================================
    // Steps and reset values
    localparam logic [PC_W-1:0]    PC_STEP     = 13'h0001;
    localparam logic [SP_W-1:0]    SP_STEP     = 8'h02;
    localparam logic [PC_W-1:0]    PC_RESET    = 13'h0000;
    localparam logic [SP_W-1:0]    SP_RESET    = 8'h00;
    localparam logic [DATA_W-1:0]  DATA_RESET  = 8'h00;
    localparam logic [STACK_W-1:0] STACK_RESET = 16'h0000;
    localparam logic [FLAG_W-1:0]  FLAG_RESET  = 4'h0;

    // ==========================================================
    // Operations handed over by the instruction decoder
    typedef enum logic [3:0] {
        OP_NONE,                                  // Any one-cycle instruction not handled here
        OP_CMP_IMM,                               // Compare with immediate, skip if equal
        OP_CMP_MEM,                               // Compare with data byte, skip if equal
        OP_CALL,
        OP_JUMP,
        OP_RET_VAL,                               // Load immediate, then return
        OP_RET,
        OP_RETI,
        OP_PCADD
    } op_t;

endpackage

// ---- sub_flags.sv ----
// Eight-bit subtractor that yields the four arithmetic flags of a minus b
`timescale 1ns/1ps

module sub_flags (
    input  wire logic [7:0] minuend,           // Working register value
    input  wire logic [7:0] subtrahend,        // Immediate or data byte
    output logic            zero,              // Difference is zero
    output logic            carry,             // Borrow out of bit 7
    output logic            half_borrow_flag,  // Borrow out of bit 3
    output logic            signed_wrap_flag   // Signed overflow
);

    logic [8:0] diff_full;
    logic [4:0] diff_low;

    // ==========================================================
    // Borrow chain; extra top bit carries the borrow out
    always_comb begin
        diff_full        = {1'b0, minuend} - {1'b0, subtrahend};
        diff_low         = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]};
        zero             = (diff_full[7:0] == 8'h00);
        carry            = diff_full[8];
        half_borrow_flag = diff_low[4];
        // Wrap only when operand signs differ and the result sign flips from the minuend
        signed_wrap_flag = (minuend[7] ^ subtrahend[7]) & (minuend[7] ^ diff_full[7]);
    end

endmodule

// ---- program_flow_control.sv ----
// Execution of compare-and-skip and control-transfer instructions
// What this block does
// - Compare immediate: skip if equal, set flags
// - Compare data byte: skip if equal, set flags
// - Call pushes next address, jumps, stack up two
// - Jump loads any target, flags untouched
// - Return-with-value loads working register, then returns
// - Return: stack down two, reload counter
// - Interrupt return resumes and enables interrupts
// - Computed jump adds working register to counter
// - Transfers take two cycles, others one
// - Compare-skip takes two cycles only when skipping
`timescale 1ns/1ps

module program_flow_control (
    input  wire logic                                mclk,             // System clock, 50 MHz
    input  wire logic                                rst,              // Asynchronous reset, active high
    input  wire logic                                exec_valid,       // Decoder offers an instruction
    output logic                                     exec_ready,       // Block takes the offered instruction
    input  wire flow_pkg::op_t                       exec_op,          // Decoded operation
    input  wire logic [flow_pkg::DATA_W-1:0]         exec_imm,         // Immediate operand
    input  wire logic [flow_pkg::PC_W-1:0]           exec_target,      // Jump or call target
    input  wire logic [flow_pkg::DATA_W-1:0]         mem_data,         // Addressed data byte
    input  wire logic [flow_pkg::DATA_W-1:0]         working_register, // Current working register
    input  wire logic [flow_pkg::PC_W-1:0]           program_counter,  // Address of this instruction
    input  wire logic [flow_pkg::SP_W-1:0]           stack_pointer,    // Current stack pointer
    output logic                                     stack_we,         // Write one stack entry
    output logic                                     stack_re,         // Read one stack entry
    output logic [flow_pkg::SP_W-1:0]                stack_addr,       // Stack entry address
    output logic [flow_pkg::STACK_W-1:0]             stack_wdata,      // Entry written
    input  wire logic [flow_pkg::STACK_W-1:0]        stack_rdata,      // Entry read, same cycle
    output logic                                     pc_load,          // Load program counter
    output logic [flow_pkg::PC_W-1:0]                pc_value,         // New program counter
    output logic                                     sp_load,          // Load stack pointer
    output logic [flow_pkg::SP_W-1:0]                sp_value,         // New stack pointer
    output logic                                     acc_we,           // Write working register
    output logic [flow_pkg::DATA_W-1:0]              acc_value,        // Working register value
    output logic                                     flag_we,          // Write the four flags
    output logic [flow_pkg::FLAG_W-1:0]              flags_out,        // Flag word
    output logic                                     gie_set,          // Set global interrupt enable
    output logic                                     skip_pulse        // A skip was decided
);

    typedef enum logic [1:0] {ST_READY, ST_BUSY, ST_SUPPRESS} state_t;

    state_t                       state_q, state_d;
    logic                         stack_we_q, stack_we_d, stack_re_q, stack_re_d;
    logic [flow_pkg::SP_W-1:0]    stack_addr_q, stack_addr_d;
    logic [flow_pkg::STACK_W-1:0] stack_wdata_q, stack_wdata_d;
    logic                         pc_load_q, pc_load_d, from_stack_q, from_stack_d;
    logic [flow_pkg::PC_W-1:0]    pc_value_q, pc_value_d;
    logic                         sp_load_q, sp_load_d;
    logic [flow_pkg::SP_W-1:0]    sp_value_q, sp_value_d;
    logic                         acc_we_q, acc_we_d;
    logic [flow_pkg::DATA_W-1:0]  acc_value_q, acc_value_d;
    logic                         flag_we_q, flag_we_d;
    logic [flow_pkg::FLAG_W-1:0]  flags_q, flags_d;
    logic                         gie_q, gie_d, skip_q, skip_d;
    logic [flow_pkg::DATA_W-1:0]  cmp_operand;
    logic                         f_zero, f_carry, f_half, f_wrap;
    logic                         take;
    logic                         long_op;

    // ==========================================================
    // Compare operand and flag arithmetic
    assign cmp_operand = (exec_op == flow_pkg::OP_CMP_IMM) ? exec_imm : mem_data;

    sub_flags u_sub (
        .minuend          (working_register),
        .subtrahend       (cmp_operand),
        .zero             (f_zero),
        .carry            (f_carry),
        .half_borrow_flag (f_half),
        .signed_wrap_flag (f_wrap)
    );

    // A busy cycle refuses; a suppress cycle accepts and drops
    assign exec_ready = (state_q != ST_BUSY);
    assign take       = exec_valid && exec_ready;
    assign long_op    = exec_op inside {flow_pkg::OP_CALL, flow_pkg::OP_JUMP, flow_pkg::OP_RET_VAL,
                                        flow_pkg::OP_RET, flow_pkg::OP_RETI, flow_pkg::OP_PCADD};

    // ==========================================================
    // Next-state and effect decode
    always_comb begin
        state_d       = state_q;
        stack_we_d    = 1'b0;
        stack_re_d    = 1'b0;
        stack_addr_d  = stack_addr_q;
        stack_wdata_d = stack_wdata_q;
        pc_load_d     = 1'b0;
        from_stack_d  = 1'b0;
        pc_value_d    = pc_value_q;
        sp_load_d     = 1'b0;
        sp_value_d    = sp_value_q;
        acc_we_d      = 1'b0;
        acc_value_d   = acc_value_q;
        flag_we_d     = 1'b0;
        flags_d       = flags_q;
        gie_d         = 1'b0;
        skip_d        = 1'b0;
        unique case (state_q)
            ST_BUSY: begin
                state_d = ST_READY;
            end
            ST_SUPPRESS: begin
                // Skipped instruction is consumed with no effect at all
                if (exec_valid) begin
                    state_d = ST_READY;
                end
            end
            ST_READY: begin
                if (exec_valid) begin
                    if (long_op) begin
                        state_d = ST_BUSY;
                    end
                    unique case (exec_op)
                        flow_pkg::OP_CMP_IMM, flow_pkg::OP_CMP_MEM: begin
                            flag_we_d                     = 1'b1;
                            flags_d[flow_pkg::FLAG_ZERO]  = f_zero;
                            flags_d[flow_pkg::FLAG_CARRY] = f_carry;
                            flags_d[flow_pkg::FLAG_HALF]  = f_half;
                            flags_d[flow_pkg::FLAG_WRAP]  = f_wrap;
                            if (f_zero) begin
                                skip_d  = 1'b1;
                                state_d = ST_SUPPRESS;
                            end
                        end
                        flow_pkg::OP_CALL: begin
                            stack_we_d    = 1'b1;
                            stack_addr_d  = stack_pointer;
                            stack_wdata_d = {{(flow_pkg::STACK_W-flow_pkg::PC_W){1'b0}},
                                             program_counter + flow_pkg::PC_STEP};
                            sp_load_d     = 1'b1;
                            sp_value_d    = stack_pointer + flow_pkg::SP_STEP;
                            pc_load_d     = 1'b1;
                            pc_value_d    = exec_target;
                        end
                        flow_pkg::OP_JUMP: begin
                            pc_load_d  = 1'b1;
                            pc_value_d = exec_target;
                        end
                        flow_pkg::OP_RET_VAL, flow_pkg::OP_RET, flow_pkg::OP_RETI: begin
                            // Pointer drops first; the entry below it holds the return address
                            sp_load_d    = 1'b1;
                            sp_value_d   = stack_pointer - flow_pkg::SP_STEP;
                            stack_re_d   = 1'b1;
                            stack_addr_d = stack_pointer - flow_pkg::SP_STEP;
                            pc_load_d    = 1'b1;
                            from_stack_d = 1'b1;
                            if (exec_op == flow_pkg::OP_RET_VAL) begin
                                acc_we_d    = 1'b1;
                                acc_value_d = exec_imm;
                            end
                            if (exec_op == flow_pkg::OP_RETI) begin
                                gie_d = 1'b1;
                            end
                        end
                        flow_pkg::OP_PCADD: begin
                            pc_load_d  = 1'b1;
                            pc_value_d = program_counter + {{(flow_pkg::PC_W-flow_pkg::DATA_W){1'b0}},
                                                            working_register};
                        end
                        flow_pkg::OP_NONE: begin
                        end
                        default: begin
                            // Unused operation codes act as a one-cycle no-op
                        end
                    endcase
                end
            end
        endcase
    end

    // ==========================================================
    // State registers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_q       <= ST_READY;
            stack_we_q    <= 1'b0;
            stack_re_q    <= 1'b0;
            stack_addr_q  <= flow_pkg::SP_RESET;
            stack_wdata_q <= flow_pkg::STACK_RESET;
            pc_load_q     <= 1'b0;
            from_stack_q  <= 1'b0;
            pc_value_q    <= flow_pkg::PC_RESET;
            sp_load_q     <= 1'b0;
            sp_value_q    <= flow_pkg::SP_RESET;
            acc_we_q      <= 1'b0;
            acc_value_q   <= flow_pkg::DATA_RESET;
            flag_we_q     <= 1'b0;
            flags_q       <= flow_pkg::FLAG_RESET;
            gie_q         <= 1'b0;
            skip_q        <= 1'b0;
        end else begin
            state_q       <= state_d;
            stack_we_q    <= stack_we_d;
            stack_re_q    <= stack_re_d;
            stack_addr_q  <= stack_addr_d;
            stack_wdata_q <= stack_wdata_d;
            pc_load_q     <= pc_load_d;
            from_stack_q  <= from_stack_d;
            pc_value_q    <= pc_value_d;
            sp_load_q     <= sp_load_d;
            sp_value_q    <= sp_value_d;
            acc_we_q      <= acc_we_d;
            acc_value_q   <= acc_value_d;
            flag_we_q     <= flag_we_d;
            flags_q       <= flags_d;
            gie_q         <= gie_d;
            skip_q        <= skip_d;
        end
    end

    // ==========================================================
    // Outputs; return address passes straight from the stack read to save a cycle
    assign stack_we    = stack_we_q;
    assign stack_re    = stack_re_q;
    assign stack_addr  = stack_addr_q;
    assign stack_wdata = stack_wdata_q;
    assign pc_load     = pc_load_q;
    assign pc_value    = from_stack_q ? stack_rdata[flow_pkg::PC_W-1:0] : pc_value_q;
    assign sp_load     = sp_load_q;
    assign sp_value    = sp_value_q;
    assign acc_we      = acc_we_q;
    assign acc_value   = acc_value_q;
    assign flag_we     = flag_we_q;
    assign flags_out   = flags_q;
    assign gie_set     = gie_q;
    assign skip_pulse  = skip_q;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    property p_cmp_imm;
        take && state_q == ST_READY && exec_op == flow_pkg::OP_CMP_IMM
        |=> flag_we && flags_out[flow_pkg::FLAG_ZERO] == ($past(working_register) == $past(exec_imm))
            && skip_pulse == flags_out[flow_pkg::FLAG_ZERO];
    endproperty
    a_cmp_imm: assert property (p_cmp_imm) else $error("compare immediate flag or skip wrong");

    property p_cmp_mem;
        take && state_q == ST_READY && exec_op == flow_pkg::OP_CMP_MEM && working_register < mem_data
        |=> flag_we && flags_out[flow_pkg::FLAG_CARRY] && !skip_pulse && state_q == ST_READY;
    endproperty
    a_cmp_mem: assert property (p_cmp_mem) else $error("compare memory borrow wrong");

    property p_call;
        take && state_q == ST_READY && exec_op == flow_pkg::OP_CALL
        |=> stack_we && stack_addr == $past(stack_pointer) && sp_load
            && sp_value == $past(stack_pointer) + flow_pkg::SP_STEP
            && stack_wdata[flow_pkg::PC_W-1:0] == $past(program_counter) + flow_pkg::PC_STEP
            && pc_value == $past(exec_target) && !flag_we;
    endproperty
    a_call: assert property (p_call) else $error("call effects wrong");

    property p_jump;
        take && state_q == ST_READY && exec_op == flow_pkg::OP_JUMP
        |=> pc_load && pc_value == $past(exec_target) && !flag_we && !stack_we;
    endproperty
    a_jump: assert property (p_jump) else $error("jump target wrong");

    property p_ret_val;
        take && state_q == ST_READY && exec_op == flow_pkg::OP_RET_VAL
        |=> acc_we && acc_value == $past(exec_imm) && stack_re && pc_load && !flag_we;
    endproperty
    a_ret_val: assert property (p_ret_val) else $error("return with value wrong");

    property p_ret;
        take && state_q == ST_READY && exec_op == flow_pkg::OP_RET
        |=> stack_re && sp_load && pc_load && !flag_we
            && stack_addr == $past(stack_pointer) - flow_pkg::SP_STEP && sp_value == stack_addr
            && pc_value == stack_rdata[flow_pkg::PC_W-1:0] && !acc_we;
    endproperty
    a_ret: assert property (p_ret) else $error("return address wrong");

    property p_reti;
        take && state_q == ST_READY && exec_op == flow_pkg::OP_RETI |=> gie_set && stack_re && !flag_we;
    endproperty
    a_reti: assert property (p_reti) else $error("interrupt return wrong");

    property p_pcadd;
        take && state_q == ST_READY && exec_op == flow_pkg::OP_PCADD
        |=> pc_load && pc_value == $past(program_counter) + $past(working_register);
    endproperty
    a_pcadd: assert property (p_pcadd) else $error("computed jump wrong");

    property p_two_cycle;
        take && state_q == ST_READY && long_op |=> !exec_ready ##1 exec_ready;
    endproperty
    a_two_cycle: assert property (p_two_cycle) else $error("transfer not two cycles");

    property p_skip_timing;
        skip_pulse |-> state_q == ST_SUPPRESS && exec_ready;
    endproperty
    a_skip_timing: assert property (p_skip_timing) else $error("skip did not open suppress slot");

    property p_suppress;
        state_q == ST_SUPPRESS && exec_valid
        |=> !pc_load && !flag_we && !stack_we && !acc_we && !sp_load && !gie_set && !skip_pulse;
    endproperty
    a_suppress: assert property (p_suppress) else $error("skipped instruction had an effect");

    c_call: cover property (take && exec_op == flow_pkg::OP_CALL);
    c_ret: cover property (take && exec_op == flow_pkg::OP_RET ##2 exec_ready);
    c_skip: cover property (skip_pulse ##1 exec_valid);
    c_pcadd: cover property (take && exec_op == flow_pkg::OP_PCADD);

endmodule

// ---- stack_memory_model.sv ----
// Behavioural data-memory stack sitting on the far side of the flow block
`timescale 1ns/1ps

module stack_memory_model (
    input  wire logic                            mclk,        // System clock
    input  wire logic                            stack_we,    // Write one entry
    input  wire logic                            stack_re,    // Read one entry
    input  wire logic [flow_pkg::SP_W-1:0]       stack_addr,  // Entry address
    input  wire logic [flow_pkg::STACK_W-1:0]    stack_wdata, // Entry written
    output logic      [flow_pkg::STACK_W-1:0]    stack_rdata  // Entry read, same cycle
);
    logic [flow_pkg::STACK_W-1:0] mem [0:(1<<flow_pkg::SP_W)-1];

    // ==========================================================
    // Storage: starts cleared so a return without a call still reads a known word
    initial begin
        for (int i = 0; i < (1 << flow_pkg::SP_W); i++) begin
            mem[i] = 16'h0000;
        end
    end

    // Push lands on the edge that ends the write pulse
    always @(posedge mclk) begin
        if (stack_we) begin
            mem[stack_addr] <= stack_wdata;
        end
    end

    // Read is combinational; outside a read the bus shows the inverse so stale data never looks valid
    assign stack_rdata = stack_re ? mem[stack_addr] : ~mem[stack_addr];
endmodule

// ---- program_flow_control_tb.sv ----
// Self-checking testbench for the program-flow execution block
`timescale 1ns/1ps

module program_flow_control_tb;
    logic mclk = 1'b0, rst = 1'b1, exec_valid = 1'b0, exec_ready, stack_we, stack_re, pc_load, sp_load;
    logic acc_we, flag_we, gie_set, skip_pulse;
    flow_pkg::op_t exec_op = flow_pkg::OP_NONE;
    logic [7:0]  exec_imm = 8'h00, mem_data = 8'h00, working_register = 8'h00, stack_pointer = 8'h00;
    logic [7:0]  stack_addr, sp_value, acc_value;
    logic [12:0] exec_target = 13'h0000, program_counter = 13'h0000, pc_value;
    logic [15:0] stack_wdata, stack_rdata;
    logic [3:0]  flags_out;
    int          failures = 0, tests_run = 0, cycles = 0;

    // ==========================================================
    // Clock, design and far-side stack
    always #10 mclk = ~mclk;

    program_flow_control u_program_flow_control (.mclk(mclk), .rst(rst), .exec_valid(exec_valid),
        .exec_ready(exec_ready), .exec_op(exec_op), .exec_imm(exec_imm), .exec_target(exec_target),
        .mem_data(mem_data), .working_register(working_register), .program_counter(program_counter),
        .stack_pointer(stack_pointer), .stack_we(stack_we), .stack_re(stack_re), .stack_addr(stack_addr),
        .stack_wdata(stack_wdata), .stack_rdata(stack_rdata), .pc_load(pc_load), .pc_value(pc_value),
        .sp_load(sp_load), .sp_value(sp_value), .acc_we(acc_we), .acc_value(acc_value), .flag_we(flag_we),
        .flags_out(flags_out), .gie_set(gie_set), .skip_pulse(skip_pulse));

    stack_memory_model u_stack_memory_model (.mclk(mclk), .stack_we(stack_we), .stack_re(stack_re),
        .stack_addr(stack_addr), .stack_wdata(stack_wdata), .stack_rdata(stack_rdata));

    // ==========================================================
    // Reporting
    // Wide enough for the longest packed group of outputs, so no field falls off the top
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Hang guard: the whole run needs well under a hundred cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            stop_test();
        end
    end

    // Flags of a minus b worked out independently: carry and half flag are borrows
    function automatic logic [3:0] sub_flags_of(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] d;
        d = a - b;
        return {(a[7] != b[7]) && (d[7] != a[7]), a[3:0] < b[3:0], a < b, d == 8'h00};
    endfunction

    // ==========================================================
    // Offer one instruction at a falling edge; returns at the falling edge of the answer cycle
    task automatic issue(input flow_pkg::op_t op, input logic [7:0] imm, input logic [12:0] tgt,
                         input logic [7:0] mdat, input logic [7:0] wr, input logic [12:0] pc,
                         input logic [7:0] sp);
        int n;
        exec_op = op; exec_imm = imm; exec_target = tgt; mem_data = mdat;
        working_register = wr; program_counter = pc; stack_pointer = sp; exec_valid = 1'b1;
        n = 0;
        while (exec_ready !== 1'b1 && n < 10) begin
            @(negedge mclk);
            n++;
        end
        @(negedge mclk);
    endtask

    // Compare, both unequal then equal; skipped jump must vanish, the next one runs
    task automatic test_compare(input flow_pkg::op_t op);
        issue(op, 8'h42, 13'h0000, 8'h42, 8'h38, 13'h0010, 8'h00);
        check({flag_we, skip_pulse, flags_out}, {2'b10, sub_flags_of(8'h38, 8'h42)});
        issue(op, 8'h01, 13'h0000, 8'h01, 8'h80, 13'h0011, 8'h00);               // back to back after no skip
        check({flag_we, skip_pulse, flags_out, exec_ready}, {2'b10, sub_flags_of(8'h80, 8'h01), 1'b1});
        issue(op, 8'h55, 13'h0000, 8'h55, 8'h55, 13'h0012, 8'h00);
        check({flag_we, skip_pulse, flags_out, pc_load}, {2'b11, 4'h1, 1'b0});
        issue(flow_pkg::OP_JUMP, 8'h00, 13'h0777, 8'h00, 8'h00, 13'h0013, 8'h00);
        check({pc_load, flag_we, sp_load, stack_we}, 4'b0000);
        issue(flow_pkg::OP_JUMP, 8'h00, 13'h0555, 8'h00, 8'h00, 13'h0014, 8'h00);
        check({pc_load, pc_value}, {1'b1, 13'h0555});
        exec_valid = 1'b0;
        @(negedge mclk);
        $display("compare test done, op %0d", op);
    endtask

    // Call to the top of program space, then a request held through the busy cycle
    task automatic test_call();
        issue(flow_pkg::OP_CALL, 8'h00, 13'h1FFF, 8'h00, 8'h00, 13'h0ABC, 8'h10);
        check({stack_we, stack_addr, stack_wdata}, {1'b1, 8'h10, 16'h0ABD});
        check({pc_load, pc_value, sp_load, sp_value}, {1'b1, 13'h1FFF, 1'b1, 8'h12});
        check({flag_we, exec_ready}, 2'b00);
        issue(flow_pkg::OP_JUMP, 8'h00, 13'h1000, 8'h00, 8'h00, 13'h1FFF, 8'h12);
        check({pc_load, pc_value, flag_we}, {1'b1, 13'h1000, 1'b0});
        exec_valid = 1'b0;
        @(negedge mclk);
        $display("call test done");
    endtask

    // Each return kind reads back the pushed address
    task automatic test_returns();
        flow_pkg::op_t ops [3];
        ops = '{flow_pkg::OP_RET, flow_pkg::OP_RET_VAL, flow_pkg::OP_RETI};
        for (int i = 0; i < 3; i++) begin
            issue(ops[i], 8'hA5, 13'h0000, 8'h00, 8'h00, 13'h0200, 8'h12);
            check({stack_re, stack_addr, sp_load, sp_value}, {1'b1, 8'h10, 1'b1, 8'h10});
            check({pc_load, pc_value, flag_we, exec_ready}, {1'b1, 13'h0ABD, 2'b00});
            check({acc_we, gie_set}, {i == 1, i == 2});
            if (i == 1) check(acc_value, 8'hA5);
            exec_valid = 1'b0;
            @(negedge mclk);
        end
        $display("return test done");
    endtask

    // Computed jump with the largest unsigned addend, then a plain one-cycle instruction
    task automatic test_pcadd();
        issue(flow_pkg::OP_PCADD, 8'h00, 13'h0000, 8'h00, 8'hFF, 13'h1F00, 8'h00);
        check({pc_load, pc_value, flag_we, exec_ready}, {1'b1, 13'h1FFF, 2'b00});
        issue(flow_pkg::OP_NONE, 8'h00, 13'h0000, 8'h00, 8'h00, 13'h1FFF, 8'h00);
        check({pc_load, flag_we, stack_we, stack_re, sp_load, acc_we, gie_set, skip_pulse, exec_ready},
              9'h001);
        exec_valid = 1'b0;
        @(negedge mclk);
        $display("computed jump test done");
    endtask

    // Reset in the busy cycle of a call drops every pulse; a jump right after release runs
    task automatic test_reset();
        issue(flow_pkg::OP_CALL, 8'h00, 13'h0100, 8'h00, 8'h00, 13'h0020, 8'h20);
        rst        = 1'b1;
        exec_valid = 1'b0;
        @(negedge mclk);
        check({exec_ready, pc_load, stack_we, sp_load, flag_we, skip_pulse}, 6'h20);
        rst = 1'b0;
        issue(flow_pkg::OP_JUMP, 8'h00, 13'h0321, 8'h00, 8'h00, 13'h0000, 8'h00);
        check({pc_load, pc_value, flag_we}, {1'b1, 13'h0321, 1'b0});
        exec_valid = 1'b0;
        @(negedge mclk);
        $display("reset test done");
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (2) @(negedge mclk);
        rst = 1'b0;
        check({exec_ready, pc_load, stack_we, skip_pulse}, 4'b1000);
        test_compare(flow_pkg::OP_CMP_IMM);
        test_compare(flow_pkg::OP_CMP_MEM);
        test_call();
        test_returns();
        test_pcadd();
        test_reset();
        stop_test();
    end
endmodule
